/* File: dv/spcd_slave_model.sv */
`default_nettype none
module spcd_slave_model (
  // Serial lines
  input  wire logic       sclk,
  input  wire logic       mosi,
  output var  logic       miso,
  // Mode and preload
  input  wire logic       clock_idle_level,
  input  wire logic       clock_launch_edge,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output var  logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_reg;
  int         edges;
  always @(posedge load) begin
    tx_reg = tx_byte;
    edges = 0;
    miso = tx_byte[7];
  end
  // Leading edge leaves the idle level; the edge that does not launch samples
  always @(sclk) begin
    if (edges < 16) begin
      if ((sclk != clock_idle_level) != clock_launch_edge) begin
        rx_byte = {rx_byte[6:0], mosi};
      end else if (edges > 0) begin
        tx_reg = tx_reg << 1;
        miso = tx_reg[7];
      end
      edges = edges + 1;
      // After the sixteenth edge the line is inverted so it shows no stale bit
      if (edges == 16) miso = ~miso;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`default_nettype none
module tb_top;
  import spcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk, rst, sfr_wr, sfr_rd, load, irq, miso_m;
  logic       s_sclk, s_mosi, s_ss_n;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rx_byte, tx, rd;
  logic [3:0] port_latch, port_out, port_oe, port_in, mode;
  int         failures, checks_done, cycles;
  // Pin levels: serial clock bit 0, data out bit 1, data in bit 2, select bit 3
  assign port_in = (port_oe & port_out) | (~port_oe & {s_ss_n, miso_m, s_mosi, s_sclk});
  spcd_top i_spcd_top (.SYS_CLK(sys_clk), .RST(rst), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
    .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .PORT_LATCH(port_latch),
    .PORT_IN(port_in), .PORT_OUT(port_out), .PORT_OE(port_oe), .IRQ(irq));
  spcd_slave_model i_spcd_slave_model (.sclk(port_out[0]), .mosi(port_out[1]), .miso(miso_m),
    .clock_idle_level(mode[3]), .clock_launch_edge(mode[2]), .load(load), .tx_byte(tx), .rx_byte(rx_byte));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1 rd = sfr_rdata;
    @(posedge sys_clk);
  endtask
  task automatic wait_irq();
    for (int c = 0; c < 400 && irq !== 1'b1; c++) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask
  task automatic test_reset();
    rdr(SPCD_ADDR_CONTROL);
    check(rd, 8'h05);
    rdr(SPCD_ADDR_SHIFTDATA);
    check(rd, 8'h00);
    rdr(8'h10);
    check(rd, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_master(input logic [7:0] d, input logic [7:0] r);
    int first, last, n;
    logic prev;
    wr(SPCD_ADDR_CONTROL, {4'h3, mode});
    // Let a polarity change settle before the partner starts counting edges
    repeat (2) @(posedge sys_clk);
    tx <= r;
    load <= 1'b1;
    #1 check({7'h0, port_out[0]}, {7'h0, mode[3]});
    wr(SPCD_ADDR_SHIFTDATA, d);
    load <= 1'b0;
    prev = mode[3];
    n = 0;
    first = 0;
    last = 0;
    for (int c = 0; c < 400 && irq !== 1'b1; c++) begin
      @(posedge sys_clk);
      #1;
      if (port_out[0] !== prev) begin
        if (n == 0) first = c;
        last = c;
        n++;
      end
      prev = port_out[0];
    end
    @(posedge sys_clk);
    check(8'(n), 8'd16);
    check(8'(last - first), 8'(15 << mode[1:0]));
    check(rx_byte, d);
    rdr(SPCD_ADDR_CONTROL);
    check(rd, {4'hb, mode});
    rdr(SPCD_ADDR_SHIFTDATA);
    check(rd, r);
    rdr(SPCD_ADDR_CONTROL);
    check(rd, {4'h3, mode});
    $display("test master mode %h done", mode);
  endtask
  task automatic test_collision();
    mode <= 4'h1;
    wr(SPCD_ADDR_CONTROL, 8'h31);
    repeat (2) @(posedge sys_clk);
    tx <= 8'h5a;
    load <= 1'b1;
    wr(SPCD_ADDR_SHIFTDATA, 8'ha5);
    load <= 1'b0;
    @(posedge sys_clk);
    wr(SPCD_ADDR_SHIFTDATA, 8'h3c);
    rdr(SPCD_ADDR_CONTROL);
    check(rd & 8'h40, 8'h40);
    wait_irq();
    check(rx_byte, 8'ha5);
    wr(SPCD_ADDR_CONTROL, 8'h31);
    rdr(SPCD_ADDR_CONTROL);
    check(rd, 8'h31);
    $display("test collision done");
  endtask
  task automatic test_slave(input logic [7:0] d, input logic [7:0] m);
    logic [7:0] got;
    int         b;
    wr(SPCD_ADDR_CONTROL, {4'h2, mode});
    @(posedge sys_clk);
    wr(SPCD_ADDR_SHIFTDATA, d);
    s_sclk <= mode[3];
    s_mosi <= m[7];
    repeat (2) @(posedge sys_clk);
    s_ss_n <= 1'b0;
    got = 8'h00;
    b = 6;
    for (int k = 0; k < 16; k++) begin
      repeat (4) @(posedge sys_clk);
      if (k[0] == mode[2]) got = {got[6:0], port_in[2]};
      else if (k != 0 && b >= 0) begin
        s_mosi <= m[b];
        b--;
      end
      s_sclk <= ~s_sclk;
    end
    repeat (4) @(posedge sys_clk);
    check({7'h0, irq}, 8'h01);
    s_ss_n <= 1'b1;
    @(posedge sys_clk);
    check(got, d);
    rdr(SPCD_ADDR_CONTROL);
    check(rd, {4'ha, mode});
    rdr(SPCD_ADDR_SHIFTDATA);
    check(rd, m);
    $display("test slave mode %h done", mode);
  endtask
  task automatic test_pins();
    wr(SPCD_ADDR_CONTROL, 8'h00);
    port_latch <= 4'ha;
    repeat (2) @(posedge sys_clk);
    check({port_oe, port_out}, 8'h5a);
    wr(SPCD_ADDR_CONTROL, 8'h20);
    repeat (2) @(posedge sys_clk);
    check({7'h0, port_oe[0]}, 8'h00);
    $display("test pins done");
  endtask
  initial begin
    {sfr_wr, sfr_rd, load, rst} = 4'h1;
    {s_sclk, s_mosi, s_ss_n} = 3'h7;
    {sfr_addr, sfr_wdata, tx, mode, port_latch} = '0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    test_reset();
    for (int m = 0; m < 16; m++) begin
      mode = 4'(m);
      test_master(8'(8'h96 + m), 8'(8'h3c ^ m));
    end
    test_collision();
    for (int m = 0; m < 4; m++) begin
      mode = 4'(m << 2);
      test_slave(8'(8'hc3 + m), 8'(8'h69 ^ m));
    end
    test_pins();
    close_out();
  end
endmodule
`default_nettype wire

/* File: inc/spcd_pkg.sv */
`default_nettype none
package spcd_pkg;
  // SFR addresses
  localparam logic [7:0] SPCD_ADDR_CONTROL   = 8'hf8;
  localparam logic [7:0] SPCD_ADDR_SHIFTDATA = 8'h7f;
  // Reset values
  localparam logic [7:0] SPCD_RST_CONTROL    = 8'h05;
  localparam logic [7:0] SPCD_RST_SHIFTDATA  = 8'h00;
  // Control register field positions
  localparam int SPCD_BIT_DONE  = 7;
  localparam int SPCD_BIT_WRITE_COLLISION_FLAG  = 6;
  localparam int SPCD_BIT_EN    = 5;
  localparam int SPCD_BIT_MSTR  = 4;
  localparam int SPCD_BIT_IDLE  = 3;
  localparam int SPCD_BIT_PHASE = 2;
  localparam int SPCD_BIT_RATE  = 0;
  // Port 2 pin positions
  localparam int SPCD_PIN_SCLK = 0;
  localparam int SPCD_PIN_MOSI = 1;
  localparam int SPCD_PIN_MISO = 2;
  localparam int SPCD_PIN_SS   = 3;
  localparam int SPCD_BITS     = 8;
  // Interrupt vector shared with the two-wire interface
  localparam logic [7:0] SPCD_VECTOR = 8'h3b;
endpackage
`default_nettype wire

/* File: src/spcd_top.sv */
// Functional notes
// - The transfer-done flag, bit 7 of the control register, sets when a transfer ends.
// - The transfer-done flag clears on a software write of zero or on a read of shift data.
// - The write-collision flag, bit 6, sets on a shift-data write during a transfer; software clears it.
// - Enable bit 5 hands the shared port pins to the serial port; when zero they act as port pins.
// - Master bit 4 makes the block master driving the serial clock, else slave taking it in.
// - Bit 3 set makes the serial clock idle high, clear idle low.
// - Bit 2 set launches data on the leading clock edge, clear on the trailing edge.
// - In master mode the rate bits divide the core clock by 2, 4, 8 or 16.
// - Master and slave should use identical polarity and phase settings.
// - The serial interrupt shares one vector with the two-wire interface.
// - Shift data is eight bits at its own address, resets to zero, not bit addressable.
// - Serial clock, MOSI, MISO and slave select sit on port bits 0 to 3.
`default_nettype none
module spcd_top
  import spcd_pkg::*;
(
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  // Special-function register access
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output var  logic [7:0] SFR_RDATA,
  // Port 2 latch and pins
  input  wire logic [3:0] PORT_LATCH,
  input  wire logic [3:0] PORT_IN,
  output var  logic [3:0] PORT_OUT,
  output var  logic [3:0] PORT_OE,
  // Interrupt request toward the shared vector
  output var  logic       IRQ
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MRUN = 3'b010,
    ST_SRUN = 3'b100
  } spcd_state_t;

  function automatic logic [3:0] half_period(input logic [1:0] rate);
    half_period = (4'h1 << rate) - 4'h1;
  endfunction

  spcd_state_t state_reg, state_next;
  logic [7:0] ctl_reg, ctl_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] div_reg, div_next;
  logic [3:0] edge_reg, edge_next;
  logic       sclk_reg, sclk_next;
  logic       mosi_reg, mosi_next;
  logic       sin_reg, sin_next;
  logic       sprev_reg, sprev_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [3:0] pout_reg, pout_next;
  logic [3:0] poe_reg, poe_next;
  logic       irq_reg, irq_next;

  logic en, mstr, clock_idle_level, clock_launch_edge;
  logic wr_ctl, wr_dat, rd_dat, busy, done, sel_low, sedge, lead;
  assign en     = ctl_reg[SPCD_BIT_EN];
  assign mstr   = ctl_reg[SPCD_BIT_MSTR];
  assign clock_idle_level   = ctl_reg[SPCD_BIT_IDLE];
  assign clock_launch_edge   = ctl_reg[SPCD_BIT_PHASE];
  assign wr_ctl = SFR_WR && SFR_ADDR == SPCD_ADDR_CONTROL;
  assign wr_dat = SFR_WR && SFR_ADDR == SPCD_ADDR_SHIFTDATA;
  assign rd_dat = SFR_RD && SFR_ADDR == SPCD_ADDR_SHIFTDATA;
  assign busy   = state_reg != ST_IDLE;
  assign sel_low = !PORT_IN[SPCD_PIN_SS];
  assign sedge  = PORT_IN[SPCD_PIN_SCLK] != sprev_reg;
  // Leading edge leaves the idle level
  assign lead   = (PORT_IN[SPCD_PIN_SCLK] != clock_idle_level);

  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    div_next   = div_reg;
    edge_next  = edge_reg;
    sclk_next  = sclk_reg;
    mosi_next  = mosi_reg;
    sin_next   = sin_reg;
    sprev_next = PORT_IN[SPCD_PIN_SCLK];
    done       = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        sclk_next = clock_idle_level;
        if (wr_dat) begin
          shift_next = SFR_WDATA;
        end
        if (en && mstr && wr_dat) begin
          state_next = ST_MRUN;
          div_next   = half_period(ctl_reg[SPCD_BIT_RATE +: 2]);
          edge_next  = 4'h0;
          mosi_next  = SFR_WDATA[7];
        end else if (en && !mstr && sel_low) begin
          state_next = ST_SRUN;
          edge_next  = 4'h0;
          mosi_next  = shift_reg[7];
        end
      end
      ST_MRUN: begin
        if (div_reg != 4'h0) begin
          div_next = div_reg - 4'h1;
        end else begin
          div_next  = half_period(ctl_reg[SPCD_BIT_RATE +: 2]);
          sclk_next = !sclk_reg;
          edge_next = edge_reg + 4'h1;
          // Odd edges (0-based even index) are leading; sample on the non-launch edge
          if (edge_reg[0] == clock_launch_edge) begin
            sin_next = PORT_IN[SPCD_PIN_MISO];
            // Last edge samples the final bit straight into the register
            if (edge_reg == 4'hf) begin
              shift_next = {shift_reg[6:0], PORT_IN[SPCD_PIN_MISO]};
            end
          end else if (edge_reg != 4'h0 || !clock_launch_edge) begin
            // First leading edge keeps the msb that went out with the write
            shift_next = {shift_reg[6:0], sin_reg};
            mosi_next  = shift_reg[6];
          end
          if (edge_reg == 4'hf) begin
            state_next = ST_IDLE;
            done       = 1'b1;
          end
        end
        if (!en) begin
          state_next = ST_IDLE;
        end
      end
      ST_SRUN: begin
        if (sedge) begin
          edge_next = edge_reg + 4'h1;
          if (lead != clock_launch_edge) begin
            sin_next = PORT_IN[SPCD_PIN_MOSI];
            // Last edge samples the final bit straight into the register
            if (edge_reg == 4'hf) begin
              shift_next = {shift_reg[6:0], PORT_IN[SPCD_PIN_MOSI]};
            end
          end else if (edge_reg != 4'h0 || !clock_launch_edge) begin
            shift_next = {shift_reg[6:0], sin_reg};
            mosi_next  = shift_reg[6];
          end
          if (edge_reg == 4'hf) begin
            state_next = ST_IDLE;
            done       = 1'b1;
          end
        end
        if (!en || mstr || !sel_low) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_comb begin
    ctl_next = ctl_reg;
    if (wr_ctl) begin
      ctl_next = SFR_WDATA;
      ctl_next[SPCD_BIT_DONE] = ctl_reg[SPCD_BIT_DONE] & SFR_WDATA[SPCD_BIT_DONE];
      ctl_next[SPCD_BIT_WRITE_COLLISION_FLAG] = ctl_reg[SPCD_BIT_WRITE_COLLISION_FLAG] & SFR_WDATA[SPCD_BIT_WRITE_COLLISION_FLAG];
    end
    if (rd_dat) begin
      ctl_next[SPCD_BIT_DONE] = 1'b0;
    end
    if (done) begin
      ctl_next[SPCD_BIT_DONE] = 1'b1;
    end
    if (wr_dat && busy) begin
      ctl_next[SPCD_BIT_WRITE_COLLISION_FLAG] = 1'b1;
    end
    rdata_next = 8'h00;
    if (SFR_RD && SFR_ADDR == SPCD_ADDR_CONTROL) begin
      rdata_next = ctl_reg;
    end else if (rd_dat) begin
      rdata_next = shift_reg;
    end
    irq_next = ctl_next[SPCD_BIT_DONE];
  end

  always_comb begin
    pout_next = PORT_LATCH;
    poe_next  = ~PORT_LATCH;
    if (en) begin
      pout_next = 4'h0;
      poe_next  = 4'h0;
      if (mstr) begin
        pout_next[SPCD_PIN_SCLK] = sclk_next;
        pout_next[SPCD_PIN_MOSI] = mosi_next;
        poe_next[SPCD_PIN_SCLK]  = 1'b1;
        poe_next[SPCD_PIN_MOSI]  = 1'b1;
      end else if (sel_low) begin
        pout_next[SPCD_PIN_MISO] = mosi_next;
        poe_next[SPCD_PIN_MISO]  = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      ctl_reg   <= SPCD_RST_CONTROL;
      shift_reg <= SPCD_RST_SHIFTDATA;
      div_reg   <= 4'h0;
      edge_reg  <= 4'h0;
      sclk_reg  <= 1'b0;
      mosi_reg  <= 1'b0;
      sin_reg   <= 1'b0;
      sprev_reg <= 1'b0;
      rdata_reg <= 8'h00;
      pout_reg  <= 4'h0;
      poe_reg   <= 4'h0;
      irq_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctl_reg   <= ctl_next;
      shift_reg <= shift_next;
      div_reg   <= div_next;
      edge_reg  <= edge_next;
      sclk_reg  <= sclk_next;
      mosi_reg  <= mosi_next;
      sin_reg   <= sin_next;
      sprev_reg <= sprev_next;
      rdata_reg <= rdata_next;
      pout_reg  <= pout_next;
      poe_reg   <= poe_next;
      irq_reg   <= irq_next;
    end
  end

  assign SFR_RDATA = rdata_reg;
  assign PORT_OUT  = pout_reg;
  assign PORT_OE   = poe_reg;
  assign IRQ       = irq_reg;

  sequence seq_master_start;
    state_reg == ST_IDLE && en && mstr && wr_dat;
  endsequence

  AST_DONE_SET: assert property (@(posedge SYS_CLK) disable iff (RST)
    done |=> ctl_reg[SPCD_BIT_DONE])
    else $error("done flag not set after transfer");
  AST_DONE_RDCLR: assert property (@(posedge SYS_CLK) disable iff (RST)
    rd_dat && !done |=> !ctl_reg[SPCD_BIT_DONE])
    else $error("done flag not cleared by data read");
  AST_WRITE_COLLISION_FLAG_SET: assert property (@(posedge SYS_CLK) disable iff (RST)
    wr_dat && busy |=> ctl_reg[SPCD_BIT_WRITE_COLLISION_FLAG])
    else $error("collision flag not set");
  AST_WRITE_COLLISION_FLAG_HOLD: assert property (@(posedge SYS_CLK) disable iff (RST)
    ctl_reg[SPCD_BIT_WRITE_COLLISION_FLAG] && !wr_ctl |=> ctl_reg[SPCD_BIT_WRITE_COLLISION_FLAG])
    else $error("collision flag cleared without software");
  AST_PORT_MODE: assert property (@(posedge SYS_CLK) disable iff (RST)
    !$past(RST) && !en && !$past(en) |-> PORT_OUT == $past(PORT_LATCH))
    else $error("pins not returned to port use");
  AST_MASTER_CLK: assert property (@(posedge SYS_CLK) disable iff (RST)
    en && $past(en) && mstr && $past(mstr) |-> PORT_OE[SPCD_PIN_SCLK])
    else $error("master does not drive clock");
  AST_SLAVE_CLK: assert property (@(posedge SYS_CLK) disable iff (RST)
    en && $past(en) && !mstr && !$past(mstr) |-> !PORT_OE[SPCD_PIN_SCLK])
    else $error("slave drives clock");
  AST_IDLE_LVL: assert property (@(posedge SYS_CLK) disable iff (RST)
    state_reg == ST_IDLE && $past(state_reg) == ST_IDLE && !$past(wr_ctl)
      && $past(state_reg, 2) == ST_IDLE |-> sclk_reg == clock_idle_level)
    else $error("clock not at idle level");
  AST_DIV2_LEN: assert property (@(posedge SYS_CLK) disable iff (RST)
    seq_master_start ##0 (ctl_reg[1:0] == 2'b00 && !wr_ctl) ##1 (!wr_ctl && en)[*8]
      ##1 (!wr_ctl && en)[*8] |=> state_reg == ST_IDLE && ctl_reg[SPCD_BIT_DONE])
    else $error("divide-by-two transfer length wrong");
endmodule
`default_nettype wire
